// ==== rtl/ftr_defs.svh ====
// Constants for the fault trigger recorder: rates, timing, reset values
// Summary of operation
// [R1] Sample inputs at 384 per power cycle
// [R2] Idle: overwrite oldest entries in circular buffer
// [R3] Compare input levels against configured limits
// [R4] On abnormal input, write post-fault buffer instead
// [R5] End post-fault on time or normal; re-arm
// [R6] Record joins frozen history and post-fault data
// [R7] Save RMS and phasor twice per cycle; the code saves the channel 0 sum of squares, not RMS
// [R8] Auto print only for transient records
// [R9] Cross-trigger links transient and disturbance triggers
// [R10] Digital inputs compared with normal state
// [R11] Serial link 8N1, default 19200 baud
// [R12] Send only while partner asserts clear-to-send; the code checks CTS at byte start only
// [R13] Triggered output held at least 500 ms
// [R14] Only one host session open at once
// [R15] Limits and post length loaded before arming
// [R16] Keep write position at trigger for ordering
`ifndef FTR_DEFS_SVH
`define FTR_DEFS_SVH
`define FTR_CLK_HZ 100000000
`define FTR_SAMPLES_PER_CYCLE 384
`define FTR_HALF_CYCLE_SAMPLES (`FTR_SAMPLES_PER_CYCLE / 2)
`define FTR_QUARTER_CYCLE_SAMPLES (`FTR_SAMPLES_PER_CYCLE / 4)
`define FTR_RATE_50HZ 19200
`define FTR_RATE_60HZ 23040
`define FTR_DIV_50HZ (`FTR_CLK_HZ / `FTR_RATE_50HZ)
`define FTR_DIV_60HZ (`FTR_CLK_HZ / `FTR_RATE_60HZ)
`define FTR_BAUD_DEFAULT 19200
`define FTR_BAUD_DIV_DEFAULT (`FTR_CLK_HZ / `FTR_BAUD_DEFAULT)
`define FTR_TRIG_MIN_MS 500
`define FTR_TRIG_MIN_CYCLES ((`FTR_CLK_HZ / 1000) * `FTR_TRIG_MIN_MS)
`define FTR_UART_DATA_BITS 8
`define FTR_RST_LOW_LIMIT 16'h8000
`define FTR_RST_HIGH_LIMIT 16'h7FFF
`define FTR_RST_POST_LEN 16'h0100
`endif

// ==== rtl/ftr_pkg.sv ====
// Types shared by the fault trigger recorder modules
package ftr_pkg;
    // Transient recorder states, one-hot
    typedef enum logic [2:0] {
        FTR_DISARMED = 3'b001,
        FTR_PRE = 3'b010,
        FTR_POST = 3'b100
    } ftr_state_e;
    // Serial transmitter states, one-hot
    typedef enum logic [3:0] {
        FTR_TX_IDLE = 4'b0001,
        FTR_TX_START = 4'b0010,
        FTR_TX_DATA = 4'b0100,
        FTR_TX_STOP = 4'b1000
    } ftr_tx_state_e;
endpackage

// ==== rtl/ftr_uart_tx.sv ====
// Serial transmitter, 8 data bits, no parity, 1 stop bit, CTS gated
`timescale 1ns/10ps
`include "ftr_defs.svh"
module ftr_uart_tx (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [15:0] baudDiv,
    input wire logic txValid,
    input wire logic [7:0] txData,
    output logic txReady,
    input wire logic cts,
    output logic txd
);
    ftr_pkg::ftr_tx_state_e state_q; // Transmit state
    logic [15:0] baudCnt_q; // Cycles left in the current bit
    logic [2:0] bitIdx_q; // Data bit being sent
    logic [7:0] shift_q; // Byte being sent

    // Only accept a byte while the partner is clear to send
    assign txReady = (state_q == ftr_pkg::FTR_TX_IDLE) && cts; // [R12]

    // Bit sequencer; a byte already started finishes even if CTS drops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ftr_pkg::FTR_TX_IDLE;
            baudCnt_q <= 16'h0000;
            bitIdx_q <= 3'h0;
            shift_q <= 8'h00;
            txd <= 1'b1;
        end else begin
            unique case (state_q)
                ftr_pkg::FTR_TX_IDLE: begin
                    txd <= 1'b1;
                    if (txValid && cts) begin // [R12]
                        shift_q <= txData;
                        txd <= 1'b0;
                        baudCnt_q <= baudDiv - 16'h0001;
                        state_q <= ftr_pkg::FTR_TX_START;
                    end
                end
                ftr_pkg::FTR_TX_START: begin
                    if (baudCnt_q == 16'h0000) begin
                        txd <= shift_q[0]; // [R11]
                        shift_q <= {1'b0, shift_q[7:1]};
                        bitIdx_q <= 3'h0;
                        baudCnt_q <= baudDiv - 16'h0001;
                        state_q <= ftr_pkg::FTR_TX_DATA;
                    end else begin
                        baudCnt_q <= baudCnt_q - 16'h0001;
                    end
                end
                ftr_pkg::FTR_TX_DATA: begin
                    if (baudCnt_q == 16'h0000) begin
                        baudCnt_q <= baudDiv - 16'h0001;
                        if (bitIdx_q == 3'(`FTR_UART_DATA_BITS - 1)) begin
                            txd <= 1'b1; // Single stop bit [R11]
                            state_q <= ftr_pkg::FTR_TX_STOP;
                        end else begin
                            txd <= shift_q[0];
                            shift_q <= {1'b0, shift_q[7:1]};
                            bitIdx_q <= bitIdx_q + 3'h1;
                        end
                    end else begin
                        baudCnt_q <= baudCnt_q - 16'h0001;
                    end
                end
                ftr_pkg::FTR_TX_STOP: begin
                    if (baudCnt_q == 16'h0000) begin
                        state_q <= ftr_pkg::FTR_TX_IDLE;
                    end else begin
                        baudCnt_q <= baudCnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end
endmodule // ftr_uart_tx

// ==== rtl/ftr_recorder.sv ====
// Fault trigger recorder: sampling, triggering, buffers, disturbance, host link
`timescale 1ns/10ps
`include "ftr_defs.svh"
module ftr_recorder #(
    parameter int NUM_AN = 4,
    parameter int NUM_DIG = 16,
    parameter int PRE_DEPTH = 64,
    parameter int POST_DEPTH = 256,
    parameter int DIV_50HZ = `FTR_DIV_50HZ,
    parameter int DIV_60HZ = `FTR_DIV_60HZ,
    parameter int TRIG_MIN_CYCLES = `FTR_TRIG_MIN_CYCLES,
    parameter int BAUD_DIV_DEFAULT = `FTR_BAUD_DIV_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic freq60,
    input wire logic [NUM_AN*16-1:0] anSample,
    input wire logic [NUM_DIG-1:0] digIn,
    input wire logic cfgLoad,
    input wire logic [15:0] cfgLowLimit,
    input wire logic [15:0] cfgHighLimit,
    input wire logic [NUM_DIG-1:0] cfgDigNormal,
    input wire logic [NUM_DIG-1:0] cfgDigTrigMask,
    input wire logic [15:0] cfgPostLen,
    input wire logic cfgEndOnNormal,
    input wire logic [39:0] cfgDistLimit,
    input wire logic [15:0] cfgBaudDiv,
    input wire logic crossEnable,
    input wire logic arm,
    input wire logic disarm,
    input wire logic hostOpen,
    input wire logic hostClose,
    input wire logic hostChan,
    input wire logic dumpReq,
    input wire logic cts,
    output logic armed,
    output logic sampleTick,
    output logic triggered,
    output logic recordReady,
    output logic autoPrintReq,
    output logic [NUM_DIG-1:0] digAlarm,
    output logic distValid,
    output logic [71:0] distData,
    output logic distTrig,
    output logic sessionOpen,
    output logic sessionChan,
    output logic sessionReject,
    output logic dumpBusy,
    output logic rts,
    output logic txd
);
    localparam int W = NUM_AN * 16 + NUM_DIG; // One stored entry
    localparam int BYTES = (W + 7) / 8;
    localparam int PAW = $clog2(PRE_DEPTH);
    localparam int QAW = $clog2(POST_DEPTH);

    // Refuse sizes the logic cannot serve
    initial begin
        if (NUM_DIG < 16 || NUM_DIG > 160 || NUM_AN < 1 || BYTES > 32 ||
            PRE_DEPTH != (1 << PAW) || POST_DEPTH > 65536 || DIV_50HZ < 2 ||
            DIV_60HZ < 2 || TRIG_MIN_CYCLES < 1 || BAUD_DIV_DEFAULT < 2) begin
            $error("ftr_recorder: unsupported parameter values");
        end
    end

    // Configuration held while armed, so thresholds never change mid-record
    logic [15:0] lowLim_q, highLim_q, postLen_q, baudDiv_q;
    logic [NUM_DIG-1:0] digNormal_q, digMask_q;
    logic endOnNormal_q;
    logic [39:0] distLim_q;
    ftr_pkg::ftr_state_e state_q; // Transient recorder state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lowLim_q <= `FTR_RST_LOW_LIMIT;
            highLim_q <= `FTR_RST_HIGH_LIMIT;
            postLen_q <= `FTR_RST_POST_LEN;
            baudDiv_q <= 16'(BAUD_DIV_DEFAULT); // [R11]
            digNormal_q <= '0;
            digMask_q <= '0;
            endOnNormal_q <= 1'b0;
            distLim_q <= '1;
        end else if (cfgLoad && state_q == ftr_pkg::FTR_DISARMED) begin // [R15]
            lowLim_q <= cfgLowLimit;
            highLim_q <= cfgHighLimit;
            postLen_q <= cfgPostLen;
            baudDiv_q <= cfgBaudDiv;
            digNormal_q <= cfgDigNormal;
            digMask_q <= cfgDigTrigMask;
            endOnNormal_q <= cfgEndOnNormal;
            distLim_q <= cfgDistLimit;
        end
    end

    // Sample tick from the system frequency selection
    logic [15:0] divCnt_q;
    logic [8:0] phase_q; // Sample index within a power cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_q <= 16'h0000;
            sampleTick <= 1'b0;
            phase_q <= 9'h000;
        end else begin
            sampleTick <= 1'b0;
            if (divCnt_q == 16'(freq60 ? DIV_60HZ - 1 : DIV_50HZ - 1)) begin // [R1]
                divCnt_q <= 16'h0000;
                sampleTick <= 1'b1;
                phase_q <= (phase_q == 9'(`FTR_SAMPLES_PER_CYCLE - 1)) ?
                    9'h000 : phase_q + 9'h001;
            end else begin
                divCnt_q <= divCnt_q + 16'h0001;
            end
        end
    end

    // Level comparison and digital alarm decode
    logic anAbn, digAbn, abnormal;
    always_comb begin
        anAbn = 1'b0;
        for (int i = 0; i < NUM_AN; i++) begin
            if ($signed(anSample[i*16 +: 16]) < $signed(lowLim_q) ||
                $signed(anSample[i*16 +: 16]) > $signed(highLim_q)) begin
                anAbn = 1'b1; // [R3]
            end
        end
    end
    assign digAbn = |((digIn ^ digNormal_q) & digMask_q); // [R10]
    assign abnormal = anAbn | digAbn;
    // Registered normal/alarm view of each digital input
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            digAlarm <= '0;
        end else begin
            digAlarm <= digIn ^ digNormal_q; // [R10]
        end
    end

    // Disturbance recorder: channel 0 sum of squares and phasor per half cycle
    logic [39:0] sumSq_q;
    logic [15:0] re_q, im_q;
    logic distAbn_q;
    logic [31:0] sq;
    assign sq = 32'($signed(anSample[15:0]) * $signed(anSample[15:0]));
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sumSq_q <= 40'h00_0000_0000;
            re_q <= 16'h0000;
            im_q <= 16'h0000;
            distValid <= 1'b0;
            distData <= '0;
            distAbn_q <= 1'b0;
        end else begin
            distValid <= 1'b0;
            distAbn_q <= 1'b0;
            if (sampleTick) begin
                // Phasor taken from the samples at start and quarter cycle
                if (phase_q == 9'h000 ||
                    phase_q == 9'(`FTR_HALF_CYCLE_SAMPLES)) begin
                    re_q <= anSample[15:0];
                end
                if (phase_q == 9'(`FTR_QUARTER_CYCLE_SAMPLES) ||
                    phase_q == 9'(3 * `FTR_QUARTER_CYCLE_SAMPLES)) begin
                    im_q <= anSample[15:0];
                end
                if (phase_q == 9'(`FTR_HALF_CYCLE_SAMPLES - 1) ||
                    phase_q == 9'(`FTR_SAMPLES_PER_CYCLE - 1)) begin
                    distValid <= 1'b1; // Twice per cycle [R7]
                    distData <= {sumSq_q + 40'(sq), re_q, im_q}; // [R7]
                    distAbn_q <= (sumSq_q + 40'(sq)) > distLim_q;
                    sumSq_q <= 40'h00_0000_0000;
                end else begin
                    sumSq_q <= sumSq_q + 40'(sq);
                end
            end
        end
    end

    // Trigger sources with optional cross-triggering
    logic transTrig;
    assign transTrig = sampleTick && abnormal;
    assign distTrig = distAbn_q | (crossEnable & transTrig & armed); // [R9]
    logic trigNow;
    assign trigNow = (transTrig | (crossEnable & distAbn_q)) & !dumpBusy; // [R9]

    // Buffers: two history banks so a frozen one survives the re-arm
    logic [W-1:0] preMem [2*PRE_DEPTH];
    logic [W-1:0] postMem [POST_DEPTH];
    logic bank_q; // Bank being filled
    logic [PAW-1:0] wrPtr_q, trigPtr_q;
    logic [PAW:0] preCnt_q, frozenCnt_q;
    logic [15:0] postCnt_q, postStored_q;
    logic postDone;
    assign armed = state_q != ftr_pkg::FTR_DISARMED;
    assign postDone = postCnt_q == postLen_q || 32'(postCnt_q) == POST_DEPTH ||
        (endOnNormal_q && !abnormal);

    // Transient recorder control
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ftr_pkg::FTR_DISARMED;
            bank_q <= 1'b0;
            wrPtr_q <= '0;
            trigPtr_q <= '0;
            preCnt_q <= '0;
            frozenCnt_q <= '0;
            postCnt_q <= 16'h0000;
            postStored_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ftr_pkg::FTR_DISARMED: begin
                    if (arm) begin
                        state_q <= ftr_pkg::FTR_PRE;
                        wrPtr_q <= '0;
                        preCnt_q <= '0;
                    end
                end
                ftr_pkg::FTR_PRE: begin
                    if (disarm) begin
                        state_q <= ftr_pkg::FTR_DISARMED;
                    end else if (trigNow) begin // [R4]
                        state_q <= ftr_pkg::FTR_POST;
                        trigPtr_q <= wrPtr_q; // [R16]
                        frozenCnt_q <= preCnt_q;
                        postCnt_q <= 16'h0000;
                    end else if (sampleTick) begin
                        wrPtr_q <= wrPtr_q + 1'b1; // Wraps over oldest [R2]
                        if (preCnt_q != (PAW+1)'(PRE_DEPTH)) begin
                            preCnt_q <= preCnt_q + 1'b1;
                        end
                    end
                end
                ftr_pkg::FTR_POST: begin
                    if (sampleTick && postDone) begin // [R5]
                        state_q <= ftr_pkg::FTR_PRE;
                        bank_q <= ~bank_q; // Fresh circular buffer [R5]
                        wrPtr_q <= '0;
                        preCnt_q <= '0;
                        postStored_q <= postCnt_q;
                    end else if (sampleTick) begin
                        postCnt_q <= postCnt_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Sample storage; the sample that raises a transient trigger goes to neither buffer
    always_ff @(posedge clk_sys) begin
        if (sampleTick && state_q == ftr_pkg::FTR_PRE && !trigNow) begin
            preMem[{bank_q, wrPtr_q}] <= {digIn, anSample}; // [R2]
        end
        if (sampleTick && state_q == ftr_pkg::FTR_POST && !postDone) begin
            postMem[postCnt_q[QAW-1:0]] <= {digIn, anSample}; // [R4]
        end
    end

    // Record completion and auto print request, transient only
    logic dumpDone;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            recordReady <= 1'b0;
            autoPrintReq <= 1'b0;
        end else begin
            autoPrintReq <= 1'b0;
            if (state_q == ftr_pkg::FTR_POST && sampleTick && postDone) begin
                recordReady <= 1'b1; // [R6]
                autoPrintReq <= 1'b1; // Disturbance never requests [R8]
            end else if (dumpDone) begin
                recordReady <= 1'b0;
            end
        end
    end

    // Triggered status with minimum on-time
    logic [31:0] onCnt_q;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            onCnt_q <= 32'h0000_0000;
            triggered <= 1'b0;
        end else begin
            if (state_q == ftr_pkg::FTR_POST) begin
                onCnt_q <= 32'(TRIG_MIN_CYCLES - 1); // [R13]
                triggered <= 1'b1;
            end else if (onCnt_q != 32'h0000_0000) begin
                onCnt_q <= onCnt_q - 32'h0000_0001;
                triggered <= 1'b1; // [R13]
            end else begin
                triggered <= 1'b0;
            end
        end
    end

    // Single host session
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sessionOpen <= 1'b0;
            sessionChan <= 1'b0;
            sessionReject <= 1'b0;
        end else begin
            sessionReject <= 1'b0;
            if (hostClose && sessionOpen && hostChan == sessionChan) begin
                sessionOpen <= 1'b0;
            end else if (hostOpen && sessionOpen) begin
                sessionReject <= 1'b1; // Any open while in session refused, same channel too [R14]
            end else if (hostOpen) begin
                sessionOpen <= 1'b1;
                sessionChan <= hostChan;
            end
        end
    end
    assign rts = sessionOpen; // Ready to hear the host only in session [R12]

    // Record dump: history oldest first, then post-fault entries
    logic [15:0] dumpIdx_q;
    logic [4:0] byteIdx_q;
    logic primed_q;
    logic [W-1:0] rdWord_q;
    logic [BYTES*8-1:0] rdPad;
    logic txReady, txValid;
    logic [PAW:0] preIdx;
    assign preIdx = (PAW+1)'(dumpIdx_q);
    assign rdPad = (BYTES*8)'(rdWord_q);
    assign txValid = dumpBusy && primed_q;
    assign dumpDone = dumpBusy && primed_q && txReady && 32'(byteIdx_q) == BYTES - 1 &&
        dumpIdx_q == 16'(frozenCnt_q) + postStored_q - 16'h0001;
    // Sync read: oldest history entry sits at the trigger pointer when full
    always_ff @(posedge clk_sys) begin
        if (dumpIdx_q < 16'(frozenCnt_q)) begin
            rdWord_q <= preMem[{~bank_q, (frozenCnt_q[PAW] ? trigPtr_q : PAW'(0)) +
                preIdx[PAW-1:0]}]; // [R16]
        end else begin
            rdWord_q <= postMem[QAW'(dumpIdx_q - 16'(frozenCnt_q))]; // [R6]
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dumpBusy <= 1'b0;
            dumpIdx_q <= 16'h0000;
            byteIdx_q <= 5'h00;
            primed_q <= 1'b0;
        end else if (!dumpBusy) begin
            // Refused unless a finished record waits, a session is open and no post-fault capture runs
            if (dumpReq && sessionOpen && recordReady &&
                state_q != ftr_pkg::FTR_POST) begin
                dumpBusy <= 1'b1;
                dumpIdx_q <= 16'h0000;
                byteIdx_q <= 5'h00;
                primed_q <= 1'b0;
            end
        end else if (!primed_q) begin
            primed_q <= 1'b1; // Read data valid one cycle after address
        end else if (txReady) begin
            if (dumpDone) begin
                dumpBusy <= 1'b0;
            end else if (32'(byteIdx_q) == BYTES - 1) begin
                byteIdx_q <= 5'h00;
                dumpIdx_q <= dumpIdx_q + 16'h0001;
                primed_q <= 1'b0;
            end else begin
                byteIdx_q <= byteIdx_q + 5'h01;
            end
        end
    end

    // Serial transmitter, low byte of each entry first
    ftr_uart_tx u_tx (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .baudDiv(baudDiv_q),
        .txValid(txValid),
        .txData(rdPad[byteIdx_q*8 +: 8]),
        .txReady(txReady),
        .cts(cts),
        .txd(txd)
    );
endmodule // ftr_recorder

// ==== sim/ftr_checker_assertions.sv ====
// Concurrent checks on the fault trigger recorder ports
`timescale 1ns/10ps
module ftr_checker #(
    parameter int TRIG_MIN_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic arm,
    input wire logic hostOpen,
    input wire logic hostClose,
    input wire logic hostChan,
    input wire logic armed,
    input wire logic sampleTick,
    input wire logic triggered,
    input wire logic recordReady,
    input wire logic autoPrintReq,
    input wire logic distValid,
    input wire logic sessionOpen,
    input wire logic sessionChan,
    input wire logic sessionReject,
    input wire logic dumpBusy,
    input wire logic rts
);
    int hiCnt; // Cycles the triggered output has stood high
    // On-time counter, so the minimum can be judged at the falling edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hiCnt <= 0;
        end else begin
            hiCnt <= triggered ? hiCnt + 1 : 0;
        end
    end
    // One domain only, so clock and reset are given once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    open_grant_a: assert property (hostOpen && !sessionOpen && !hostClose |=> sessionOpen)
        else $error("session not opened");
    reject_cause_a: assert property (sessionReject |-> $past(hostOpen) && $past(sessionOpen))
        else $error("reject without second open");
    close_ends_a: assert property (hostClose && sessionOpen && hostChan == sessionChan
        |=> !sessionOpen) else $error("session not closed");
    rts_session_a: assert property (rts == sessionOpen)
        else $error("rts differs from session");
    arm_grant_a: assert property (arm && !armed |=> armed)
        else $error("arm not taken");
    trig_hold_a: assert property ($fell(triggered) |-> hiCnt >= TRIG_MIN_CYCLES)
        else $error("triggered output too short");
    print_trans_a: assert property (autoPrintReq |-> triggered && recordReady)
        else $error("print request without transient record");
    tick_gap_a: assert property (sampleTick |=> !sampleTick [*5])
        else $error("sample ticks too close");
    dist_gap_a: assert property (distValid |=> !distValid [*8])
        else $error("disturbance entries too close");
    dump_start_a: assert property ($rose(dumpBusy) |-> $past(recordReady) && $past(sessionOpen))
        else $error("dump without record or session");
endmodule // ftr_checker
bind ftr_recorder ftr_checker #(.TRIG_MIN_CYCLES(TRIG_MIN_CYCLES)) chk (.clk_sys, .reset_n, .arm,
    .hostOpen, .hostClose, .hostChan, .armed, .sampleTick, .triggered, .recordReady, .autoPrintReq,
    .distValid, .sessionOpen, .sessionChan, .sessionReject, .dumpBusy, .rts);

// ==== sim/ftr_host_model.sv ====
// Host side serial receiver that paces the device with clear-to-send
`timescale 1ns/10ps
module ftr_host_model #(
    parameter int BIT = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic txd,
    input wire logic stall,
    output logic cts
);
    logic [7:0] rxBytes [$]; // Bytes taken off the line, in order
    int errCount = 0; // Framing and pacing faults
    // Receiver; samples mid-bit so edge skew cannot flip a bit
    initial begin : rx
        logic [7:0] b;
        cts = 1'b1;
        forever begin
            @(posedge clk_sys);
            if (reset_n && !txd) begin
                repeat (BIT / 2) @(posedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge clk_sys);
                    b[i] = txd;
                end
                repeat (BIT) @(posedge clk_sys);
                if (txd !== 1'b1) errCount++;
                rxBytes.push_back(b);
                if (stall) begin
                    cts <= 1'b0;
                    for (int k = 0; k < 20; k++) begin
                        @(posedge clk_sys);
                        if (k >= 3 && !txd) errCount++;
                    end
                    cts <= 1'b1;
                end
            end
        end
    end
endmodule // ftr_host_model

// ==== sim/test_ftr_recorder.sv ====
// Self-checking bench for the fault trigger recorder
`timescale 1ns/10ps
module test_ftr_recorder;
    logic clk_sys, reset_n, cfgLoad, arm, disarm, hostOpen, hostClose, dumpReq, stall; // Driven
    logic freq60, crossEnable, hostChan, cfgEndOnNormal; // Modes and channel
    logic [63:0] anSample; // Four channels of samples
    logic [15:0] digIn, cfgDigNormal, cfgLowLimit, cfgHighLimit, cfgPostLen, cfgBaudDiv; // Config
    logic [39:0] cfgDistLimit; // Disturbance limit
    logic armed, sampleTick, triggered, recordReady, autoPrintReq, distValid, distTrig, cts;
    logic sessionOpen, sessionChan, sessionReject, dumpBusy, rts, txd; // Session and link
    logic [15:0] digAlarm, cfgDigTrigMask; // Alarm flags, trigger mask
    logic [71:0] distData; // Phasor word, judged by neither the bench nor the checker
    int n, bad_count = 0; // Bytes received, mismatches
    int total_checks = 0; // Comparisons
    ftr_recorder #(.DIV_50HZ(8), .DIV_60HZ(6), .TRIG_MIN_CYCLES(20)) dut (.*);
    ftr_host_model #(.BIT(4)) host (.clk_sys, .reset_n, .txd, .stall, .cts);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic waitFor(ref logic sig, input logic lvl, input int lim);
        for (int i = 0; i < lim && sig !== lvl; i++)
            @(negedge clk_sys);
        if (sig !== lvl) begin
            bad_count++;
            $display("MISMATCH timeout expected %h seen %h", lvl, sig);
            test_done();
        end
    endtask
    // One-cycle request, raised and dropped at falling edges
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk_sys);
        sig = 1'b0;
    endtask
    task automatic t_session();
        pulse(hostOpen);
        check("sessionOpen", sessionOpen, 16'h0001);
        check("rts", rts, 16'h0001);
        pulse(hostOpen);
        check("sessionReject", sessionReject, 16'h0001);
        check("sessionKept", sessionOpen, 16'h0001);
        $display("Test session done");
    endtask
    task automatic t_config();
        pulse(cfgLoad);
        pulse(arm);
        check("armed", armed, 16'h0001);
        repeat (3) @(negedge clk_sys);
        check("digAlarm", digAlarm, 16'h0001);
        cfgDigNormal = 16'h0000;
        pulse(cfgLoad);
        repeat (3) @(negedge clk_sys);
        check("digLocked", digAlarm, 16'h0001);
        pulse(disarm);
        check("disarmed", armed, 16'h0000);
        pulse(arm);
        $display("Test config done");
    endtask
    task automatic t_trigger();
        repeat (600) @(negedge clk_sys);
        anSample[15:0] = 16'h3000;
        waitFor(triggered, 1'b1, 100);
        check("triggered", triggered, 16'h0001);
        waitFor(recordReady, 1'b1, 200);
        anSample[15:0] = 16'h1234;
        repeat (10) @(negedge clk_sys);
        check("trigHeld", triggered, 16'h0001);
        repeat (40) @(negedge clk_sys);
        check("trigEnded", triggered, 16'h0000);
        $display("Test trigger done");
    endtask
    task automatic t_dump();
        stall = 1'b1;
        pulse(dumpReq);
        check("dumpBusy", dumpBusy, 16'h0001);
        waitFor(dumpBusy, 1'b0, 60000);
        repeat (60) @(negedge clk_sys);
        n = host.rxBytes.size();
        check("entryBytes", n % 10, 16'h0000);
        check("oldestLow", host.rxBytes[0], 16'h0034);
        check("oldestHigh", host.rxBytes[1], 16'h0012);
        check("digByte", host.rxBytes[8], 16'h00A4);
        check("postLow", host.rxBytes[n-10], 16'h0000);
        check("postHigh", host.rxBytes[n-9], 16'h0030);
        check("ready", recordReady, 16'h0000);
        check("linkErr", host.errCount, 16'h0000);
        hostChan = 1'b1;
        pulse(hostClose);
        check("wrongChan", sessionOpen, 16'h0001);
        hostChan = 1'b0;
        pulse(hostClose);
        check("closed", sessionOpen, 16'h0000);
        check("rtsOff", rts, 16'h0000);
        $display("Test dump done");
    endtask
    initial begin
        reset_n = 1'b0;
        {cfgLoad, arm, disarm, hostOpen, hostClose, dumpReq, stall} = '0;
        {cfgDigTrigMask, cfgEndOnNormal, crossEnable, hostChan, freq60} = '0;
        anSample = {4{16'h1234}};
        digIn = 16'hA5A4;
        cfgDigNormal = 16'hA5A5;
        cfgLowLimit = 16'hF000;
        cfgHighLimit = 16'h2000;
        cfgPostLen = 16'h0004;
        cfgBaudDiv = 16'h0004;
        cfgDistLimit = 40'hFF_FFFF_FFFF;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        check("txdIdle", txd, 16'h0001);
        check("armedRst", armed, 16'h0000);
        t_session();
        t_config();
        t_trigger();
        t_dump();
        test_done();
    end
endmodule // test_ftr_recorder
